// File: inc/cwm_link_if.sv
// interface carrying configuration packet words from the source to the watchdog
interface cwm_link_if;
   logic [31:0] word;
   logic        word_valid;

   modport watchdog (input word, input word_valid);
   modport source   (output word, output word_valid);
endinterface

// File: inc/cwm_pkg.sv
// package of packet words, field positions and timing counts for the config watchdog
package cwm_pkg;
   localparam int          WORD_W          = 32;
   localparam int          CNT_W           = 30;
   localparam int          PREDIV          = 256;
   localparam int          PREDIV_W        = 8;
   localparam logic [31:0] WORD_DUMMY      = 32'hffffffff;
   localparam logic [31:0] WORD_SYNC       = 32'haa995566;
   localparam logic [31:0] WORD_NOOP       = 32'h20000000;
   localparam logic [31:0] HDR_CMD_WR1     = 32'h30008001;
   localparam logic [31:0] HDR_TIMER_WR1   = 32'h30022001;
   localparam logic [31:0] CMD_NULL        = 32'h00000000;
   localparam logic [31:0] CMD_RELOAD      = 32'h00000011;
   localparam logic [31:0] CMD_RELEASE     = 32'h0000000d;
   localparam int          BIT_CFG_MON     = 30;
   localparam int          BIT_USR_MON     = 31;
   localparam logic [29:0] TIMER_RST       = 30'h00000000;
   localparam int          SEQ_LEN_RELOAD  = 12;
   localparam int          SEQ_LEN_TIMER   = 9;

   typedef enum logic [1:0] {
      CWM_ST_IDLE   = 2'b00,
      CWM_ST_SYNCED = 2'b01,
      CWM_ST_CMDARG = 2'b10,
      CWM_ST_TMRARG = 2'b11
   } cwm_port_state_t;
endpackage

// File: testbench/config_watchdog_monitor_tb.sv
// self-checking bench: source and watchdog joined by one link, a second watchdog fed by hand
module config_watchdog_monitor_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cwm_pkg::*;
   typedef struct {logic c; logic u; logic sd; logic [29:0] v; logic ec; logic eu;} cwm_row_t;
   // ordinary timer writes: monitor bits, startup state, value, expected monitor flags
   cwm_row_t rows [4] = '{'{1, 0, 0, 30'h100, 1, 0}, '{0, 1, 0, 30'h3fffffff, 0, 1},
      '{0, 0, 0, 30'h50, 0, 0}, '{1, 0, 1, 30'h100, 0, 0}};
   logic clk = 0, rst_n = 0, sd = 0, shut = 0, pdn = 0, rp_ok = 0, ce = 1;
   logic rl_req = 0, tm_req = 0, c_mon = 0, u_mon = 0, busy, done;
   logic [29:0] t_val = 30'h0, count, c0;
   logic err, fb_req, fb_act, cfg_on, usr_on, cfg_on_b;
   int bad_count = 0, n_tests = 0, i, k;
   cwm_link_if link ();
   cwm_link_if link2 ();
   cwm_watchdog #(.PRESCALE(4)) u_cwm_watchdog (.CLK(clk), .RST_N(rst_n), .CE(ce), .LINK(link),
      .STARTUP_DONE(sd), .SHUTDOWN(shut), .POWER_DOWN(pdn), .REPROGRAM_OK(rp_ok), .TIMEOUT_ERR(err),
      .FALLBACK_REQ(fb_req), .FALLBACK_ACTIVE(fb_act), .CFG_MON_ON(cfg_on), .USR_MON_ON(usr_on), .COUNT(count));
   // second watchdog sees a hand-made stream that skips the sync words
   cwm_watchdog #(.PRESCALE(4)) u_cwm_watchdog_b (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .LINK(link2),
      .STARTUP_DONE(sd), .SHUTDOWN(shut), .POWER_DOWN(pdn), .REPROGRAM_OK(rp_ok), .TIMEOUT_ERR(),
      .FALLBACK_REQ(), .FALLBACK_ACTIVE(), .CFG_MON_ON(cfg_on_b), .USR_MON_ON(), .COUNT());
   cwm_source u_cwm_source (.CLK(clk), .RST_N(rst_n), .CE(ce), .LINK(link), .RELOAD_REQ(rl_req),
      .TIMER_REQ(tm_req), .CFG_MON(c_mon), .USR_MON(u_mon), .TIMER_VALUE(t_val), .BUSY(busy), .DONE(done));
   cwm_checker u_cwm_checker (.CLK(clk), .RST_N(rst_n), .word(link.word), .word_valid(link.word_valid));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t flag got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input logic [29:0] got, input logic [29:0] lo, input logic [29:0] hi);
      n_tests++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         bad_count++;
         $display("ERROR %0t count got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask
   // one request to the source, then wait for its last word and the watchdog's update
   task automatic send(input logic rl, input logic c, input logic u, input logic [29:0] v);
      int n;
      @(posedge clk) #1;
      rl_req = rl;
      tm_req = !rl;
      c_mon = c;
      u_mon = u;
      t_val = v;
      @(posedge clk) #1;
      chk_bit(busy, 1'b1);
      rl_req = 0;
      tm_req = 0;
      for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge clk) #1;
      if (n == 40) begin
         bad_count++;
         end_sim();
      end
      chk_bit(busy, 1'b0);
      @(posedge clk) #1;
   endtask
   initial begin
      link2.word = 32'h0;
      link2.word_valid = 0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      foreach (rows[j]) begin
         sd = rows[j].sd;
         send(0, rows[j].c, rows[j].u, rows[j].v);
         chk_bit(cfg_on, rows[j].ec);
         chk_bit(usr_on, rows[j].eu);
         chk_cnt(count, rows[j].v - 30'h2, rows[j].v);
         chk_bit(err, 1'b0);
      end
      sd = 0;
      // one step per four cycles, then expiry before startup completes
      send(0, 1, 0, 30'h5);
      c0 = count;
      repeat (4) @(posedge clk);
      #1 chk_cnt(count, c0 - 30'h1, c0 - 30'h1);
      for (i = 0; i < 100 && fb_req !== 1'b1; i++) @(posedge clk) #1;
      chk_bit(fb_req, 1'b1);
      if (i == 100) end_sim();
      @(posedge clk) #1 chk_bit(err, 1'b1);
      chk_bit(fb_act, 1'b1);
      send(0, 0, 1, 30'h20);
      chk_bit(usr_on, 1'b0);
      rp_ok = 1;
      @(posedge clk) #1 rp_ok = 0;
      @(posedge clk) #1 chk_bit(fb_act, 1'b0);
      chk_bit(err, 1'b0);
      // user monitor kept alive by the reload command
      send(0, 0, 1, 30'h20);
      chk_bit(usr_on, 1'b1);
      repeat (40) @(posedge clk);
      send(1, 0, 0, 30'h0);
      chk_cnt(count, 30'h1e, 30'h20);
      chk_bit(err, 1'b0);
      // shutdown and power down each kill a running monitor
      for (k = 0; k < 2; k++) begin
         send(0, 0, 1, 30'h8);
         shut = (k == 0);
         pdn = (k == 1);
         @(posedge clk) #1 shut = 0;
         pdn = 0;
         @(posedge clk) #1 chk_bit(usr_on, 1'b0);
         repeat (60) @(posedge clk);
         #1 chk_bit(err, 1'b0);
      end
      // clock enable low freezes the countdown and the outputs
      send(0, 0, 1, 30'h20);
      c0 = count;
      ce = 0;
      repeat (12) @(posedge clk);
      #1 chk_cnt(count, c0, c0);
      ce = 1;
      send(0, 1, 0, 30'h40);
      rst_n = 0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      chk_bit(cfg_on, 1'b0);
      chk_cnt(count, TIMER_RST, TIMER_RST);
      // a timer write with no sync in front must be ignored
      for (k = 0; k < 2; k++) begin
         @(posedge clk) #1 link2.word_valid = 1;
         link2.word = (k == 0) ? HDR_TIMER_WR1 : 32'h40000010;
      end
      @(posedge clk) #1 link2.word_valid = 0;
      @(posedge clk) #1 chk_bit(cfg_on_b, 1'b0);
      end_sim();
   end
endmodule

// File: testbench/cwm_checker_sva.sv
// link-side checker for the packet words between source and watchdog
module cwm_checker
   import cwm_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic [31:0] word,
   input wire logic        word_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // every frame opens with the dummy word
   frame_open_a: assert property ($rose(word_valid) |-> word == WORD_DUMMY)
      else $error("frame did not open with dummy");
   dummy_sync_a: assert property (word_valid && word == WORD_DUMMY |=> word_valid && word == WORD_SYNC)
      else $error("sync did not follow dummy");
   sync_noop_hdr_a: assert property (word_valid && word == WORD_SYNC |=> word == WORD_NOOP ##1
      word_valid && (word == HDR_CMD_WR1 || word == HDR_TIMER_WR1))
      else $error("no-op and header did not follow sync");
   cmd_arg_a: assert property (word_valid && word == HDR_CMD_WR1 |=> word_valid &&
      (word == CMD_NULL || word == CMD_RELOAD || word == CMD_RELEASE))
      else $error("bad command argument");
   // reload is preceded by a null command and its no-op
   reload_order_a: assert property (word_valid && word == CMD_RELOAD |->
      $past(word, 1) == HDR_CMD_WR1 && $past(word, 2) == WORD_NOOP && $past(word, 3) == CMD_NULL)
      else $error("reload not preceded by null");
   timer_arg_a: assert property (word_valid && word == HDR_TIMER_WR1 |=> word_valid ##1
      word_valid && word == WORD_NOOP)
      else $error("timer argument framing wrong");
   release_noop_a: assert property (word_valid && word == CMD_RELEASE && $past(word) == HDR_CMD_WR1
      |=> word_valid && word == WORD_NOOP)
      else $error("no-op missing after release");
   frame_close_a: assert property (word_valid && word == WORD_NOOP && $past(word) == CMD_RELEASE
      |=> !word_valid)
      else $error("words continued after release");
   reload_c: cover property (word_valid && word == CMD_RELOAD);
   timer_c: cover property (word_valid && word == HDR_TIMER_WR1);
   close_c: cover property (word_valid && word == CMD_RELEASE);
endmodule

// File: verilog/cwm_source.sv
// source end: emits the reload or timer-write packet sequence on request
import cwm_pkg::*;

module cwm_source (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        CE,
   cwm_link_if.source       LINK,
   input  wire logic        RELOAD_REQ,
   input  wire logic        TIMER_REQ,
   input  wire logic        CFG_MON,
   input  wire logic        USR_MON,
   input  wire logic [29:0] TIMER_VALUE,
   output logic             BUSY,
   output logic             DONE
);
   import cwm_pkg::*;

   logic [3:0]  idx_ff;
   logic        active_ff;
   logic        is_timer_ff;
   logic [31:0] tval_ff;
   logic [31:0] word_ff;
   logic        valid_ff;
   logic [31:0] nxt_word;
   logic [3:0]  last_idx;

   assign last_idx = is_timer_ff ? 4'(SEQ_LEN_TIMER - 1) : 4'(SEQ_LEN_RELOAD - 1);

   // word table for both sequences
   always_comb begin
      nxt_word = WORD_NOOP;
      if (is_timer_ff) begin
         unique case (idx_ff)
            4'h0: nxt_word = WORD_DUMMY;
            4'h1: nxt_word = WORD_SYNC;
            4'h3: nxt_word = HDR_TIMER_WR1;
            4'h4: nxt_word = tval_ff;
            4'h6: nxt_word = HDR_CMD_WR1;
            4'h7: nxt_word = CMD_RELEASE;
            default: nxt_word = WORD_NOOP;
         endcase
      end else begin
         unique case (idx_ff)
            4'h0: nxt_word = WORD_DUMMY;
            4'h1: nxt_word = WORD_SYNC;
            4'h3: nxt_word = HDR_CMD_WR1;
            4'h4: nxt_word = CMD_NULL;
            4'h6: nxt_word = HDR_CMD_WR1;
            4'h7: nxt_word = CMD_RELOAD;
            4'h9: nxt_word = HDR_CMD_WR1;
            4'ha: nxt_word = CMD_RELEASE;
            default: nxt_word = WORD_NOOP;
         endcase
      end
   end

   // sequencer: one word per enabled cycle; timer request wins over reload
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         idx_ff      <= '0;
         active_ff   <= 1'b0;
         is_timer_ff <= 1'b0;
         tval_ff     <= '0;
      end else if (CE) begin
         if (!active_ff) begin
            idx_ff <= '0;
            if (TIMER_REQ) begin
               active_ff   <= 1'b1;
               is_timer_ff <= 1'b1;
               tval_ff     <= {USR_MON, CFG_MON, TIMER_VALUE};
            end else if (RELOAD_REQ) begin
               active_ff   <= 1'b1;
               is_timer_ff <= 1'b0;
            end
         end else if (idx_ff == last_idx) begin
            active_ff <= 1'b0;
         end else begin
            idx_ff <= idx_ff + 1'b1;
         end
      end
   end

   // registered link drive and status
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         word_ff  <= '0;
         valid_ff <= 1'b0;
         DONE     <= 1'b0;
      end else if (CE) begin
         word_ff  <= active_ff ? nxt_word : '0;
         valid_ff <= active_ff;
         DONE     <= active_ff && idx_ff == last_idx;
      end
   end

   assign LINK.word       = word_ff;
   assign LINK.word_valid = valid_ff;
   assign BUSY            = active_ff;
endmodule

// File: verilog/cwm_watchdog.sv
// watchdog end: packet decoder, prescaler and 30-bit countdown with fallback request
import cwm_pkg::*;

// Overview of operation
// - source writes timer with config-monitor bit set
// - countdown should cover whole load and startup
// - enabled watchdog counts down from loaded value
// - zero before startup done: error, fallback load
// - source writes timer with user-monitor bit set
// - reload command or timer write restarts count
// - shutdown or power down disables watchdog
// - dummy, sync, no-op open each sequence
// - reload via command header and 00000011 word
// - timer header then word is new timer
// - sequences end with release command and no-op
// - counter is thirty bits wide
// - counter steps once per 256 oscillator ticks
// - disabled during and after fallback until reprogram
module cwm_watchdog #(
   parameter int PRESCALE = cwm_pkg::PREDIV
) (
   input  wire logic  CLK,
   input  wire logic  RST_N,
   input  wire logic  CE,
   cwm_link_if.watchdog LINK,
   input  wire logic  STARTUP_DONE,
   input  wire logic  SHUTDOWN,
   input  wire logic  POWER_DOWN,
   input  wire logic  REPROGRAM_OK,
   output logic       TIMEOUT_ERR,
   output logic       FALLBACK_REQ,
   output logic       FALLBACK_ACTIVE,
   output logic       CFG_MON_ON,
   output logic       USR_MON_ON,
   output logic [29:0] COUNT
);
   import cwm_pkg::*;

   cwm_port_state_t          state_ff;
   logic [CNT_W-1:0]         count_ff;
   logic [CNT_W-1:0]         reload_ff;
   logic                     cfg_mon_ff;
   logic                     usr_mon_ff;
   logic [PREDIV_W-1:0]      div_ff;
   logic                     tick;
   logic                     err_ff;
   logic                     fb_req_ff;
   logic                     fb_lock_ff;
   logic                     cmd_hdr;
   logic                     tmr_hdr;
   logic                     reload_cmd;
   logic                     release_cmd;
   logic                     tmr_write;
   logic                     enabled;
   logic                     kill;
   logic                     expire;

   // decode of words arriving on the packet port
   assign cmd_hdr     = LINK.word_valid && state_ff == CWM_ST_SYNCED && LINK.word == HDR_CMD_WR1;
   assign tmr_hdr     = LINK.word_valid && state_ff == CWM_ST_SYNCED && LINK.word == HDR_TIMER_WR1;
   assign reload_cmd  = LINK.word_valid && state_ff == CWM_ST_CMDARG && LINK.word == CMD_RELOAD;
   assign release_cmd = LINK.word_valid && state_ff == CWM_ST_CMDARG && LINK.word == CMD_RELEASE;
   assign tmr_write   = LINK.word_valid && state_ff == CWM_ST_TMRARG;
   assign enabled     = cfg_mon_ff || usr_mon_ff;
   assign kill        = SHUTDOWN || POWER_DOWN;
   assign expire      = enabled && tick && count_ff == '0;

   // predivider tick; a parameter so a bench can shorten it
   assign tick = (div_ff == PREDIV_W'(PRESCALE - 1));

   // port framing: nothing is decoded until the sync word is seen
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_ff <= CWM_ST_IDLE;
      end else if (CE && LINK.word_valid) begin
         unique case (state_ff)
            CWM_ST_IDLE:   state_ff <= (LINK.word == WORD_SYNC) ? CWM_ST_SYNCED : CWM_ST_IDLE;
            CWM_ST_SYNCED: begin
               if (cmd_hdr) begin
                  state_ff <= CWM_ST_CMDARG;
               end else if (tmr_hdr) begin
                  state_ff <= CWM_ST_TMRARG;
               end else begin
                  state_ff <= CWM_ST_SYNCED;  // dummy and no-op words are skipped
               end
            end
            CWM_ST_CMDARG: state_ff <= release_cmd ? CWM_ST_IDLE : CWM_ST_SYNCED;
            CWM_ST_TMRARG: state_ff <= CWM_ST_SYNCED;
         endcase
      end
   end

   // prescaler only runs while a monitor is on, so every reload starts a full period
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         div_ff <= '0;
      end else if (CE) begin
         if (!enabled || tmr_write || reload_cmd) begin
            div_ff <= '0;
         end else if (tick) begin
            div_ff <= '0;
         end else begin
            div_ff <= div_ff + 1'b1;
         end
      end
   end

   // monitor enables and reload value; shutdown and fallback lock override writes
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cfg_mon_ff <= 1'b0;
         usr_mon_ff <= 1'b0;
         reload_ff  <= TIMER_RST;
      end else if (CE) begin
         if (tmr_write) begin
            reload_ff <= LINK.word[CNT_W-1:0];
         end
         if (kill || expire || (fb_lock_ff && !REPROGRAM_OK)) begin
            cfg_mon_ff <= 1'b0;
            usr_mon_ff <= 1'b0;
         end else if (tmr_write) begin
            cfg_mon_ff <= LINK.word[BIT_CFG_MON];
            usr_mon_ff <= LINK.word[BIT_USR_MON];
         end else if (cfg_mon_ff && STARTUP_DONE) begin
            cfg_mon_ff <= 1'b0;  // startup reached its end: load supervision is over
         end
      end
   end

   // countdown: restart on timer write or reload command
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         count_ff <= TIMER_RST;
      end else if (CE) begin
         if (tmr_write) begin
            count_ff <= LINK.word[CNT_W-1:0];
         end else if (reload_cmd && enabled) begin
            count_ff <= reload_ff;
         end else if (enabled && tick && count_ff != '0) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end

   // time-out flag and one-cycle fallback request; lock holds until a good reprogram
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         err_ff     <= 1'b0;
         fb_req_ff  <= 1'b0;
         fb_lock_ff <= 1'b0;
      end else if (CE) begin
         fb_req_ff <= expire && !kill && !(cfg_mon_ff && STARTUP_DONE);
         if (expire && !kill && !(cfg_mon_ff && STARTUP_DONE)) begin
            err_ff     <= 1'b1;
            fb_lock_ff <= 1'b1;
         end else if (REPROGRAM_OK) begin
            err_ff     <= 1'b0;
            fb_lock_ff <= 1'b0;
         end
      end
   end

   // registered outputs
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         TIMEOUT_ERR     <= 1'b0;
         FALLBACK_REQ    <= 1'b0;
         FALLBACK_ACTIVE <= 1'b0;
         CFG_MON_ON      <= 1'b0;
         USR_MON_ON      <= 1'b0;
         COUNT           <= '0;
      end else if (CE) begin
         TIMEOUT_ERR     <= err_ff;
         FALLBACK_REQ    <= fb_req_ff;
         FALLBACK_ACTIVE <= fb_lock_ff;
         CFG_MON_ON      <= cfg_mon_ff;
         USR_MON_ON      <= usr_mon_ff;
         COUNT           <= count_ff;
      end
   end
endmodule
